// [rtl/ppmc_defs.svh]
`ifndef PPMC_DEFS_SVH
`define PPMC_DEFS_SVH

// Register offsets
`define PPMC_CTRL_ADDR 8'h00
`define PPMC_STAT_ADDR 8'h04
`define PPMC_EXT2_ADDR 8'h08
`define PPMC_ABIL_ADDR 8'h0C
`define PPMC_LATCH_ADDR 8'h10

// Control register fields
`define PPMC_CTRL_SWRST 15
`define PPMC_CTRL_SPEED 13
`define PPMC_CTRL_NEGEN 12
`define PPMC_CTRL_PDOWN 11
`define PPMC_CTRL_FDX 8

// Extended control fields
`define PPMC_EXT2_GATE100 0
`define PPMC_EXT2_GATE10 1

// Ability bits, highest performance first
`define PPMC_AB_100FD 3
`define PPMC_AB_100HD 2
`define PPMC_AB_10FD 1
`define PPMC_AB_10HD 0

// Reset values
`define PPMC_SPEED_DEF 1'b1
`define PPMC_NEGEN_DEF 1'b1
`define PPMC_PDOWN_DEF 1'b0
`define PPMC_FDX_DEF 1'b0
`define PPMC_GATE_DEF 1'b0
`define PPMC_ABIL_DEF 4'hF
`define PPMC_LL_DEF 1'b0
`define PPMC_LH_DEF 1'b0
`define PPMC_LMX_DEF 4'h0

// Software reset lasts four 50 MHz reference clocks
`define PPMC_CLK_NS 20
`define PPMC_SWRST_NS 80
`define PPMC_SWRST_CYC ((`PPMC_SWRST_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)

`endif

// [rtl/ppmc_pkg.sv]
package ppmc_pkg;

   typedef enum logic [1:0] {
      PPMC_RUN,
      PPMC_PDOWN,
      PPMC_SWRST
   } ppmc_state_t;

endpackage : ppmc_pkg

// [rtl/ppmc_sync.sv]
`timescale 1ns/1ps
module ppmc_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_reg;

   // First stage is read only by the second
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_reg <= '0;
         sync_o <= '0;
      end
      else if (ce_i)
      begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end

endmodule : ppmc_sync

// [rtl/ppmc_top.sv]
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ppmc_defs.svh"
module ppmc_top
   import ppmc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic hw_reset_low_pin_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic tx_en_pin_i,
   input wire logic rx_act_pin_i,
   input wire logic link_up_i,
   input wire logic fault_i,
   input wire logic [3:0] level_i,
   input wire logic [3:0] lp_ability_i,
   input wire logic lp_valid_i,
   input wire logic tx_sym_i,
   output logic crs_o,
   output logic col_o,
   output logic loopback_10_o,
   output logic sqe_test_en_o,
   output logic line_tx_plus_o,
   output logic line_tx_plus_oe_n_o,
   output logic line_tx_minus_o,
   output logic line_tx_minus_oe_n_o,
   output logic en_100_mod_o,
   output logic en_10_mod_o,
   output logic coder_100_en_o,
   output logic neg_enable_o,
   output logic [3:0] adv_ability_o,
   output logic speed_100_o,
   output logic full_duplex_o,
   output logic powered_down_o
);

   logic [2:0] sync_vec;
   logic hw_pin_sync;
   logic tx_act;
   logic rx_act;

   ppmc_sync #(
      .W(3)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .async_i({hw_reset_low_pin_i, tx_en_pin_i, rx_act_pin_i}),
      .sync_o(sync_vec)
   );

   assign hw_pin_sync = sync_vec[2];
   assign tx_act = sync_vec[1];
   assign rx_act = sync_vec[0];

   ppmc_state_t state_reg;
   ppmc_state_t state_next;
   logic [2:0] swrst_cnt_reg;
   logic speed_bit_reg;
   logic negen_bit_reg;
   logic pdown_bit_reg;
   logic fdx_bit_reg;
   logic gate100_reg;
   logic gate10_reg;
   logic [3:0] abil_reg;
   logic ll_link_reg;
   logic lh_fault_reg;
   logic [3:0] lmx_level_reg;
   logic speed_reg;
   logic fdx_reg;
   logic neg_done_reg;

   logic hw_rst;
   logic load_defaults;
   logic wr_ctrl;
   logic swrst_req;
   logic pd_now;
   logic pd_bit_entry;
   logic rd_latch;
   logic [3:0] common;

   // Hardware reset holds the registers at defaults and forces power-down
   assign hw_rst = !hw_pin_sync;
   assign load_defaults = hw_rst || (state_reg == PPMC_SWRST);
   assign wr_ctrl = wr_i && (addr_i == `PPMC_CTRL_ADDR) && !load_defaults;
   assign swrst_req = wr_ctrl && wdata_i[`PPMC_CTRL_SWRST];
   assign rd_latch = rd_i && (addr_i == `PPMC_LATCH_ADDR);
   assign pd_bit_entry = (state_reg == PPMC_RUN) && (state_next == PPMC_PDOWN) && !hw_rst;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PPMC_RUN:
         begin
            if (hw_rst || pdown_bit_reg)
               state_next = PPMC_PDOWN;
            else if (swrst_req)
               state_next = PPMC_SWRST;
         end
         PPMC_PDOWN:
         begin
            if (!hw_rst && !pdown_bit_reg)
               state_next = PPMC_RUN;
            else if (swrst_req && !hw_rst)
               state_next = PPMC_SWRST;
         end
         PPMC_SWRST:
         begin
            // Defaults clear the power-down bit, so exit is to run
            if (hw_rst)
               state_next = PPMC_PDOWN;
            else if (swrst_cnt_reg == 3'((`PPMC_SWRST_CYC) - 1))
               state_next = PPMC_RUN;
         end
         default:
            state_next = PPMC_PDOWN;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         state_reg <= PPMC_PDOWN;
      else if (ce_i)
         state_reg <= state_next;
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         swrst_cnt_reg <= 3'h0;
      else if (ce_i)
      begin
         if (state_reg == PPMC_SWRST)
            swrst_cnt_reg <= swrst_cnt_reg + 3'h1;
         else
            swrst_cnt_reg <= 3'h0;
      end
   end

   assign pd_now = (state_reg == PPMC_PDOWN);

   // Control and configuration registers
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         speed_bit_reg <= `PPMC_SPEED_DEF;
         negen_bit_reg <= `PPMC_NEGEN_DEF;
         pdown_bit_reg <= `PPMC_PDOWN_DEF;
         fdx_bit_reg <= `PPMC_FDX_DEF;
         gate100_reg <= `PPMC_GATE_DEF;
         gate10_reg <= `PPMC_GATE_DEF;
         abil_reg <= `PPMC_ABIL_DEF;
      end
      else if (ce_i)
      begin
         if (load_defaults)
         begin
            speed_bit_reg <= `PPMC_SPEED_DEF;
            negen_bit_reg <= `PPMC_NEGEN_DEF;
            pdown_bit_reg <= `PPMC_PDOWN_DEF;
            fdx_bit_reg <= `PPMC_FDX_DEF;
            gate100_reg <= `PPMC_GATE_DEF;
            gate10_reg <= `PPMC_GATE_DEF;
            abil_reg <= `PPMC_ABIL_DEF;
         end
         else if (wr_i)
         begin
            // A software reset write discards the other control bits
            if (wr_ctrl && !swrst_req)
            begin
               speed_bit_reg <= wdata_i[`PPMC_CTRL_SPEED];
               negen_bit_reg <= wdata_i[`PPMC_CTRL_NEGEN];
               pdown_bit_reg <= wdata_i[`PPMC_CTRL_PDOWN];
               fdx_bit_reg <= wdata_i[`PPMC_CTRL_FDX];
            end
            if (addr_i == `PPMC_EXT2_ADDR)
            begin
               gate100_reg <= wdata_i[`PPMC_EXT2_GATE100];
               gate10_reg <= wdata_i[`PPMC_EXT2_GATE10];
            end
            if (addr_i == `PPMC_ABIL_ADDR)
               abil_reg <= wdata_i[3:0];
         end
      end
   end

   // Latching status; a new event wins over the clear by read
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ll_link_reg <= `PPMC_LL_DEF;
         lh_fault_reg <= `PPMC_LH_DEF;
         lmx_level_reg <= `PPMC_LMX_DEF;
      end
      else if (ce_i)
      begin
         if (load_defaults || pd_bit_entry || pd_now)
         begin
            ll_link_reg <= `PPMC_LL_DEF;
            lh_fault_reg <= `PPMC_LH_DEF;
            lmx_level_reg <= `PPMC_LMX_DEF;
         end
         else
         begin
            if (!link_up_i)
               ll_link_reg <= 1'b0;
            else if (rd_latch)
               ll_link_reg <= 1'b1;
            if (fault_i)
               lh_fault_reg <= 1'b1;
            else if (rd_latch)
               lh_fault_reg <= 1'b0;
            if (rd_latch)
               lmx_level_reg <= level_i;
            else if (level_i > lmx_level_reg)
               lmx_level_reg <= level_i;
         end
      end
   end

   // Highest common mode, ordered 100FD, 100HD, 10FD, 10HD
   assign common = abil_reg & lp_ability_i;

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         speed_reg <= `PPMC_SPEED_DEF;
         fdx_reg <= `PPMC_FDX_DEF;
         neg_done_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         if (load_defaults || pd_now || !negen_bit_reg)
         begin
            speed_reg <= speed_bit_reg;
            fdx_reg <= fdx_bit_reg;
            neg_done_reg <= 1'b0;
         end
         else if (lp_valid_i && (common != 4'h0))
         begin
            neg_done_reg <= 1'b1;
            speed_reg <= common[`PPMC_AB_100FD] || common[`PPMC_AB_100HD];
            fdx_reg <= common[`PPMC_AB_100FD] ||
               (!common[`PPMC_AB_100HD] && common[`PPMC_AB_10FD]);
         end
      end
   end

   // Every output registered; power-down forces the MAC side low
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         crs_o <= 1'b0;
         col_o <= 1'b0;
         loopback_10_o <= 1'b0;
         sqe_test_en_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (pd_now || load_defaults)
         begin
            crs_o <= 1'b0;
            col_o <= 1'b0;
            loopback_10_o <= 1'b0;
            sqe_test_en_o <= 1'b0;
         end
         else if (fdx_reg)
         begin
            crs_o <= rx_act;
            col_o <= 1'b0;
            loopback_10_o <= 1'b0;
            sqe_test_en_o <= 1'b0;
         end
         else
         begin
            crs_o <= tx_act || rx_act;
            col_o <= tx_act && rx_act;
            loopback_10_o <= !speed_reg && tx_act;
            sqe_test_en_o <= !speed_reg;
         end
      end
   end

   // Line drivers released while powered down to save power
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         line_tx_plus_o <= 1'b0;
         line_tx_minus_o <= 1'b0;
         line_tx_plus_oe_n_o <= 1'b1;
         line_tx_minus_oe_n_o <= 1'b1;
      end
      else if (ce_i)
      begin
         line_tx_plus_oe_n_o <= pd_now || load_defaults;
         line_tx_minus_oe_n_o <= pd_now || load_defaults;
         line_tx_plus_o <= tx_sym_i && !pd_now;
         line_tx_minus_o <= !tx_sym_i && !pd_now;
      end
   end

   // Module enables and mode outputs
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         en_100_mod_o <= 1'b0;
         en_10_mod_o <= 1'b0;
         coder_100_en_o <= 1'b0;
         neg_enable_o <= 1'b0;
         adv_ability_o <= 4'h0;
         speed_100_o <= 1'b0;
         full_duplex_o <= 1'b0;
         powered_down_o <= 1'b1;
      end
      else if (ce_i)
      begin
         powered_down_o <= pd_now;
         en_100_mod_o <= !pd_now && !(gate100_reg && !speed_reg);
         en_10_mod_o <= !pd_now && !(gate10_reg && speed_reg);
         coder_100_en_o <= !pd_now && speed_reg;
         neg_enable_o <= !pd_now && negen_bit_reg;
         adv_ability_o <= (!pd_now && negen_bit_reg) ? abil_reg : 4'h0;
         speed_100_o <= !pd_now && speed_reg;
         full_duplex_o <= !pd_now && fdx_reg;
      end
   end

   // Management read port stays alive in power-down
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         rdata_o <= 32'h0000_0000;
      else if (ce_i)
      begin
         rdata_o <= 32'h0000_0000;
         if (rd_i)
         begin
            case (addr_i)
               `PPMC_CTRL_ADDR:
               begin
                  rdata_o[`PPMC_CTRL_SWRST] <= (state_reg == PPMC_SWRST);
                  rdata_o[`PPMC_CTRL_SPEED] <= speed_bit_reg;
                  rdata_o[`PPMC_CTRL_NEGEN] <= negen_bit_reg;
                  rdata_o[`PPMC_CTRL_PDOWN] <= pdown_bit_reg;
                  rdata_o[`PPMC_CTRL_FDX] <= fdx_bit_reg;
               end
               `PPMC_STAT_ADDR:
                  rdata_o[3:0] <= {neg_done_reg, fdx_reg, speed_reg, pd_now};
               `PPMC_EXT2_ADDR:
                  rdata_o[1:0] <= {gate10_reg, gate100_reg};
               `PPMC_ABIL_ADDR:
                  rdata_o[3:0] <= abil_reg;
               `PPMC_LATCH_ADDR:
                  rdata_o[7:0] <= {lmx_level_reg, 2'h0, lh_fault_reg, ll_link_reg};
               default:
                  rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : ppmc_top

// [verification/ppmc_checker.sv]
`timescale 1ns/1ps
`include "ppmc_defs.svh"
module ppmc_checker
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic hw_reset_low_pin_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic crs_o,
   input wire logic col_o,
   input wire logic loopback_10_o,
   input wire logic sqe_test_en_o,
   input wire logic line_tx_plus_o,
   input wire logic line_tx_plus_oe_n_o,
   input wire logic line_tx_minus_o,
   input wire logic line_tx_minus_oe_n_o,
   input wire logic en_100_mod_o,
   input wire logic coder_100_en_o,
   input wire logic neg_enable_o,
   input wire logic [3:0] adv_ability_o,
   input wire logic speed_100_o,
   input wire logic full_duplex_o,
   input wire logic powered_down_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   // Pin must be low long enough to pass the synchroniser and the state edge
   sequence s_pin_low;
      !hw_reset_low_pin_i [*5];
   endsequence
   sequence s_pd_write;
      hw_reset_low_pin_i [*4] ##0 (wr_i && addr_i == `PPMC_CTRL_ADDR && wdata_i[11] && !wdata_i[15]);
   endsequence
   a_pin_forces_down: assert property (s_pin_low |-> powered_down_o)
      else $error("pin held low but not powered down");
   a_bit_forces_down: assert property (s_pd_write |-> ##[1:3] powered_down_o)
      else $error("power-down write not obeyed");
   a_down_mac_low: assert property (powered_down_o |-> !crs_o && !col_o && !en_100_mod_o && !speed_100_o)
      else $error("MAC side active while powered down");
   a_down_line_off: assert property (powered_down_o |-> line_tx_plus_oe_n_o && line_tx_minus_oe_n_o)
      else $error("line driven while powered down");
   a_fdx_no_col: assert property (full_duplex_o |-> !col_o)
      else $error("collision in full duplex");
   a_fdx_no_loop: assert property (full_duplex_o |-> !loopback_10_o && !sqe_test_en_o)
      else $error("loopback or SQE test in full duplex");
   a_col_has_crs: assert property (col_o |-> crs_o)
      else $error("collision without carrier");
   a_fast_coder_on: assert property (speed_100_o |-> coder_100_en_o && en_100_mod_o)
      else $error("100M path off at 100M");
   a_neg_adv_off: assert property (!neg_enable_o |-> adv_ability_o == 4'h0)
      else $error("advertising with negotiation off");
   a_line_resume: assert property ($fell(powered_down_o) |-> ##[0:2] !line_tx_plus_oe_n_o)
      else $error("line not driven after power-up");
   a_line_pair: assert property (!line_tx_plus_oe_n_o |-> line_tx_minus_o == !line_tx_plus_o)
      else $error("line pair not complementary");
endmodule : ppmc_checker
bind ppmc_top ppmc_checker ppmc_checker_i (.sys_clk_i, .reset_i, .hw_reset_low_pin_i, .addr_i, .wdata_i, .wr_i,
   .crs_o, .col_o, .loopback_10_o, .sqe_test_en_o, .line_tx_plus_o, .line_tx_plus_oe_n_o, .line_tx_minus_o,
   .line_tx_minus_oe_n_o, .en_100_mod_o, .coder_100_en_o, .neg_enable_o, .adv_ability_o, .speed_100_o,
   .full_duplex_o, .powered_down_o);

// [verification/ppmc_mac_model.sv]
`timescale 1ns/1ps
module ppmc_mac_model
(
   input wire logic sys_clk_i,
   input wire logic tx_req_i,
   input wire logic rx_req_i,
   input wire logic lp_on_i,
   input wire logic [3:0] lp_cap_i,
   input wire logic fault_req_i,
   output logic tx_en_pin_o,
   output logic rx_act_pin_o,
   output logic link_up_o,
   output logic fault_o,
   output logic [3:0] level_o,
   output logic [3:0] lp_ability_o,
   output logic lp_valid_o,
   output logic tx_sym_o
);
   initial
   begin
      {tx_en_pin_o, rx_act_pin_o, link_up_o, fault_o, level_o, lp_ability_o, lp_valid_o, tx_sym_o} = '0;
   end
   always @(posedge sys_clk_i)
   begin
      tx_en_pin_o <= tx_req_i;
      rx_act_pin_o <= rx_req_i;
      link_up_o <= 1'b1;
      fault_o <= fault_req_i;
      level_o <= level_o + 4'h3;
      // Without a partner the ability lines toggle, so stale data never looks valid
      lp_ability_o <= lp_on_i ? lp_cap_i : ~lp_ability_o;
      lp_valid_o <= lp_on_i;
      tx_sym_o <= ~tx_sym_o;
   end
endmodule : ppmc_mac_model

// [verification/test_ppmc_top.sv]
`timescale 1ns/1ps
`include "ppmc_defs.svh"
module test_ppmc_top;
   logic clk, rst, pin, wr, rd, txq, rxq, lpon, fq, ce;
   logic [1:0] m;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [3:0] lpcap, k, lvl, lpa, adv;
   logic crs, col, lb, sqe, tp, tpoe, tm, tmoe, e100, e10, cod, neg, spd, fdx, pd, txe, rxa, lnk, flt, lpv, sym;
   int n_errors = 0;
   int comparisons = 0;
   ppmc_top ppmc_top_i (.sys_clk_i(clk), .reset_i(rst), .ce_i(ce), .hw_reset_low_pin_i(pin), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_en_pin_i(txe), .rx_act_pin_i(rxa),
      .link_up_i(lnk), .fault_i(flt), .level_i(lvl), .lp_ability_i(lpa), .lp_valid_i(lpv), .tx_sym_i(sym),
      .crs_o(crs), .col_o(col), .loopback_10_o(lb), .sqe_test_en_o(sqe), .line_tx_plus_o(tp),
      .line_tx_plus_oe_n_o(tpoe), .line_tx_minus_o(tm), .line_tx_minus_oe_n_o(tmoe), .en_100_mod_o(e100),
      .en_10_mod_o(e10), .coder_100_en_o(cod), .neg_enable_o(neg), .adv_ability_o(adv), .speed_100_o(spd),
      .full_duplex_o(fdx), .powered_down_o(pd));
   ppmc_mac_model ppmc_mac_model_i (.sys_clk_i(clk), .tx_req_i(txq), .rx_req_i(rxq), .lp_on_i(lpon),
      .lp_cap_i(lpcap), .fault_req_i(fq), .tx_en_pin_o(txe), .rx_act_pin_o(rxa), .link_up_o(lnk), .fault_o(flt),
      .level_o(lvl), .lp_ability_o(lpa), .lp_valid_o(lpv), .tx_sym_o(sym));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [1:0] best(input logic [3:0] c);
      // Local abilities are all set, so the common set is the partner's
      if (c == 4'h0)
         return 2'b10;
      return c[3] ? 2'b11 : c[2] ? 2'b10 : c[1] ? 2'b01 : 2'b00;
   endfunction : best
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk((rdata & m) === e, "read data");
   endtask : rd_reg
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   task automatic final_report;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      #400_000;
      n_errors++;
      final_report();
   end
   initial
   begin
      {wr, rd, txq, rxq, lpon, fq, addr, wdata, lpcap} = '0;
      rst = 1'b1;
      ce = 1'b1;
      pin = 1'b1;
      void'($urandom(32'h0000_27f5));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      settle(6);
      rd_reg(`PPMC_CTRL_ADDR, 32'h0000_B900, 32'h0000_3000);
      rd_reg(`PPMC_EXT2_ADDR, 32'h0000_0003, 32'h0000_0000);
      rd_reg(`PPMC_ABIL_ADDR, 32'h0000_000F, 32'h0000_000F);
      rd_reg(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
      for (int i = 0; i < 12; i++)
      begin
         lpon <= 1'b1;
         // A zero common set keeps the last resolved mode, so random partners never offer nothing
         lpcap <= (i < 5) ? 4'(8'h10 >> i) : 4'($urandom_range(15, 1));
         settle(6);
         chk({spd, fdx} === best(lpcap) && neg === 1'b1 && adv === 4'hF, "negotiated mode");
      end
      m = best(lpcap);
      rd_reg(`PPMC_STAT_ADDR, 32'h0000_000F, {28'h000_0000, 1'b1, m[0], m[1], 1'b0});
      wr_reg(`PPMC_CTRL_ADDR, 32'h0000_0100);
      settle(4);
      chk(neg === 1'b0 && adv === 4'h0 && spd === 1'b0 && fdx === 1'b1, "forced mode");
      for (int g = 0; g < 8; g++)
      begin
         wr_reg(`PPMC_EXT2_ADDR, 32'(g & 3));
         wr_reg(`PPMC_CTRL_ADDR, 32'(g[2]) << 13);
         settle(4);
         chk(e100 === !(g[0] && !g[2]) && e10 === !(g[1] && g[2]) && cod === g[2], "gating");
      end
      for (int j = 0; j < 24; j++)
      begin
         k = (j < 16) ? 4'(j) : 4'($urandom);
         wr_reg(`PPMC_CTRL_ADDR, (32'(k[3]) << 13) | (32'(k[2]) << 8));
         txq <= k[0];
         rxq <= k[1];
         settle(6);
         chk(crs === (k[1] | (k[0] & !k[2])) && col === (k[0] & k[1] & !k[2]), "carrier and collision");
         chk(sqe === (!k[2] & !k[3]) && lb === (k[0] & !k[2] & !k[3]), "loopback and SQE");
      end
      fq <= 1'b1;
      rxq <= 1'b1;
      settle(1);
      fq <= 1'b0;
      wr_reg(`PPMC_EXT2_ADDR, 32'h0000_0003);
      wr_reg(`PPMC_CTRL_ADDR, 32'h0000_0800);
      settle(4);
      chk(pd === 1'b1 && crs === 1'b0 && col === 1'b0 && e100 === 1'b0 && e10 === 1'b0, "MAC side down");
      chk(tpoe === 1'b1 && tmoe === 1'b1 && tp === 1'b0 && tm === 1'b0, "line released");
      rd_reg(`PPMC_LATCH_ADDR, 32'h0000_00F3, 32'h0000_0000);
      rd_reg(`PPMC_EXT2_ADDR, 32'h0000_0003, 32'h0000_0003);
      wr_reg(`PPMC_CTRL_ADDR, 32'h0000_0000);
      settle(6);
      chk(pd === 1'b0 && tpoe === 1'b0 && tmoe === 1'b0 && crs === 1'b1, "resumed");
      // Latches were reinitialised, so this first read is only a re-arm
      rd_reg(`PPMC_LATCH_ADDR, 32'h0000_0003, 32'h0000_0000);
      rd_reg(`PPMC_LATCH_ADDR, 32'h0000_0003, 32'h0000_0001);
      // Clock enable low holds the carrier although receive activity stops
      @(posedge clk);
      ce <= 1'b0;
      rxq <= 1'b0;
      txq <= 1'b0;
      settle(6);
      chk(crs === 1'b1 && pd === 1'b0, "frozen by clock enable");
      @(posedge clk);
      ce <= 1'b1;
      settle(6);
      chk(crs === 1'b0, "released by clock enable");
      @(posedge clk) pin <= 1'b0;
      settle(8);
      chk(pd === 1'b1 && tpoe === 1'b1 && crs === 1'b0, "pin power-down");
      wr_reg(`PPMC_EXT2_ADDR, 32'h0000_0003);
      @(posedge clk) pin <= 1'b1;
      settle(8);
      rd_reg(`PPMC_EXT2_ADDR, 32'h0000_0003, 32'h0000_0000);
      wr_reg(`PPMC_EXT2_ADDR, 32'h0000_0003);
      wr_reg(`PPMC_CTRL_ADDR, 32'h0000_8800);
      for (int c = 0; c < 6; c++)
      begin
         settle(1);
         chk(pd === 1'b0, "soft reset without power-down");
      end
      rd_reg(`PPMC_EXT2_ADDR, 32'h0000_0003, 32'h0000_0000);
      rd_reg(`PPMC_CTRL_ADDR, 32'h0000_B900, 32'h0000_3000);
      final_report();
   end
endmodule : test_ppmc_top
